// ===== omlpe_core.sv
// Functional notes
// RL1: Upper byte 0x09 ORs literal into accumulator
// RL2: Literal OR result lands only in accumulator
// RL3: Only negative and zero flags updated
// RL4: Top bits 000100 select register OR, d, a
// RL5: Register OR is bitwise inclusive OR
// RL6: d=1 writes file register, d=0 accumulator
// RL7: a=0 uses access bank, ignores bank select
// RL8: a=1 joins bank select with register field
// RL9: Eight-bit field reaches whole 256-byte bank
// RL10: Pointer load writes 12-bit literal, no flags
// RL11: Copy register to accumulator or itself
// RL12: Single-word ops finish in four quarter phases
// RL13: Pointer load: high four bits, then low byte
module omlpe_core #(
  parameter int NUM_PTR = 3  // Number of indirect pointers
) (
  input  wire logic                                   clk,          // Core clock
  input  wire logic                                   nrst,         // Async reset, active low
  input  wire logic [omlpe_pkg::WORD_W-1:0]           instr_word,   // Word sampled in Q1
  input  wire logic                                   instr_valid,  // Word present in Q1
  input  wire logic [omlpe_pkg::BANK_W-1:0]           bank_sel,     // bank_select_reg value
  input  wire logic [omlpe_pkg::DATA_W-1:0]           fr_rdata,     // File register read data
  output logic      [3:0]                             phase_q,      // One-hot quarter phase
  output logic      [omlpe_pkg::ADDR_W-1:0]           fr_addr_q,    // File register address
  output logic                                        fr_rd_q,      // Read strobe, Q2
  output logic                                        fr_wr_q,      // Write strobe, Q4
  output logic      [omlpe_pkg::DATA_W-1:0]           fr_wdata_q,   // Write data
  output logic      [omlpe_pkg::DATA_W-1:0]           acc_q,        // Accumulator
  output logic                                        flag_n_q,     // Negative flag
  output logic                                        flag_z_q,     // Zero flag
  output logic                                        lp_second_q,  // Awaiting pointer word 2
  output logic      [NUM_PTR*omlpe_pkg::PTR_W-1:0]    ptr_q         // indirect_pointer array
);

  localparam int DW = omlpe_pkg::DATA_W;
  localparam int PW = omlpe_pkg::PTR_W;
  localparam int IW = omlpe_pkg::PIDX_W;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NUM_PTR < 1 || NUM_PTR > (1 << omlpe_pkg::PIDX_W)) begin : g_chk
    $error("NUM_PTR out of range");
  end

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  wire        rst_n = rst_sync_q[1];

  // Two stages so release is clean against clk
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Bank address function
  // ----------------------------------------------------------------
  function automatic logic [omlpe_pkg::ADDR_W-1:0] bank_addr(
    input logic                         abit,
    input logic [omlpe_pkg::BANK_W-1:0] bsel,
    input logic [DW-1:0]                f
  );
    logic [omlpe_pkg::BANK_W-1:0] acc_bank;
    acc_bank = (f < omlpe_pkg::ACCESS_SPLIT) ? omlpe_pkg::ACCESS_BANK_LO
                                             : omlpe_pkg::ACCESS_BANK_HI;
    bank_addr = abit ? {bsel, f}       // RL8
                     : {acc_bank, f};  // RL7 RL9
  endfunction

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  omlpe_pkg::omlpe_phase_t ph_q, ph_d;

  // Free-running quarter phases; each instruction cycle is Q1..Q4
  always_comb begin
    case (ph_q)
      omlpe_pkg::PH_Q1: ph_d = omlpe_pkg::PH_Q2;
      omlpe_pkg::PH_Q2: ph_d = omlpe_pkg::PH_Q3;
      omlpe_pkg::PH_Q3: ph_d = omlpe_pkg::PH_Q4;
      omlpe_pkg::PH_Q4: ph_d = omlpe_pkg::PH_Q1;
      default:          ph_d = omlpe_pkg::PH_Q1;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= omlpe_pkg::PH_Q1;
    end else begin
      ph_q <= ph_d; // RL12
    end
  end

  assign phase_q = ph_q;
  wire in_q1 = ph_q == omlpe_pkg::PH_Q1;
  wire in_q2 = ph_q == omlpe_pkg::PH_Q2;
  wire in_q3 = ph_q == omlpe_pkg::PH_Q3;
  wire in_q4 = ph_q == omlpe_pkg::PH_Q4;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  omlpe_dec_if dif ();

  assign dif.word   = instr_word;
  assign dif.second = lp_second_q;
  assign dif.valid  = instr_valid;

  omlpe_decode u_dec (
    .d (dif.dec)
  );

  // Latched decode, held for the rest of the instruction cycle
  omlpe_pkg::omlpe_op_t      op_q;
  logic                      dest_q;
  logic [DW-1:0]             lit_q;
  logic [omlpe_pkg::PIDX_W-1:0] pidx_q;
  logic [omlpe_pkg::KHI_W-1:0]  khi_q;
  logic [DW-1:0]             res_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_q   <= omlpe_pkg::OP_NONE;
      dest_q <= 1'b0;
      lit_q  <= '0;
      khi_q  <= '0;
    end else if (in_q1) begin
      op_q   <= dif.op;
      dest_q <= dif.dest;
      lit_q  <= dif.field;
      khi_q  <= dif.khi;
    end
  end

  // Pointer index is kept from word one for word two
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pidx_q <= '0;
    end else if (in_q1 && dif.op == omlpe_pkg::OP_LDP_HI) begin
      pidx_q <= dif.pidx; // RL13
    end
  end

  // ----------------------------------------------------------------
  // Operation classes
  // ----------------------------------------------------------------
  wire is_or_lit = op_q == omlpe_pkg::OP_OR_LIT;
  wire is_or_reg = op_q == omlpe_pkg::OP_OR_REG;
  wire is_copy   = op_q == omlpe_pkg::OP_COPY;
  wire uses_reg  = is_or_reg || is_copy;
  wire sets_flag = is_or_lit || uses_reg;
  wire to_reg    = uses_reg && dest_q;   // RL6
  wire to_acc    = is_or_lit || (uses_reg && !dest_q);

  // Process data: OR or straight copy
  wire [DW-1:0] alu_res = is_or_lit ? (acc_q | lit_q)     // RL2
                        : is_or_reg ? (acc_q | fr_rdata)  // RL5
                        : fr_rdata;                       // RL11

  // ----------------------------------------------------------------
  // File register port
  // ----------------------------------------------------------------
  // Address is set up at end of Q1 and held through Q4 for write-back
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fr_addr_q <= '0;
    end else if (in_q1) begin
      fr_addr_q <= bank_addr(dif.abit, bank_sel, dif.field); // RL7 RL8
    end
  end

  // Read strobe high in Q2, data sampled at end of Q2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fr_rd_q <= 1'b0;
    end else begin
      fr_rd_q <= in_q1 && (dif.op == omlpe_pkg::OP_OR_REG || dif.op == omlpe_pkg::OP_COPY);
    end
  end

  // Result captured while memory still drives read data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_q <= '0;
    end else if (in_q2) begin
      res_q <= alu_res;
    end
  end

  // Write strobe high in Q4 only when d selects the register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fr_wr_q    <= 1'b0;
      fr_wdata_q <= '0;
    end else begin
      fr_wr_q    <= in_q3 && to_reg; // RL6
      fr_wdata_q <= in_q3 ? res_q : fr_wdata_q;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and flags, written at end of Q4
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= omlpe_pkg::ACC_RST;
    end else if (in_q4 && to_acc) begin
      acc_q <= res_q; // RL1 RL6 RL11
    end
  end

  // Pointer loads leave flags alone; other status bits live elsewhere
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_n_q <= 1'b0;
      flag_z_q <= 1'b0;
    end else if (in_q4 && sets_flag) begin
      flag_n_q <= res_q[DW-1];       // RL3
      flag_z_q <= res_q == '0;       // RL3
    end
  end

  // ----------------------------------------------------------------
  // Pointer load, two words
  // ----------------------------------------------------------------
  // Second-word flag: set by word one, cleared after word two's cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lp_second_q <= 1'b0;
    end else if (in_q4) begin
      lp_second_q <= op_q == omlpe_pkg::OP_LDP_HI; // RL13
    end
  end

  wire ld_hi = in_q4 && op_q == omlpe_pkg::OP_LDP_HI;
  wire ld_lo = in_q4 && op_q == omlpe_pkg::OP_LDP_LO;

  // One flop bank per pointer, so no two processes share a variable
  logic [PW-1:0] ptr_bank_q [NUM_PTR];

  // Unused index values simply match no pointer
  for (genvar i = 0; i < NUM_PTR; i++) begin : g_ptr
    wire sel = pidx_q == IW'(i);
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ptr_bank_q[i] <= omlpe_pkg::PTR_RST;
      end else if (sel && ld_hi) begin
        ptr_bank_q[i][PW-1:DW] <= (PW-DW)'(khi_q); // RL10 RL13
      end else if (sel && ld_lo) begin
        ptr_bank_q[i][DW-1:0] <= lit_q; // RL10 RL13
      end
    end
    assign ptr_q[i*PW +: PW] = ptr_bank_q[i];
  end

endmodule // omlpe_core

// ===== omlpe_core_sva.sv
module omlpe_core_sva (
  input wire logic        clk,          // Clock
  input wire logic        nrst,         // Reset
  input wire logic [15:0] instr_word,   // Word
  input wire logic        instr_valid,  // Word valid
  input wire logic [3:0]  bank_sel,     // Bank
  input wire logic [7:0]  fr_rdata,     // Read data
  input wire logic [3:0]  phase_q,      // Phase
  input wire logic [11:0] fr_addr_q,    // Address
  input wire logic        fr_rd_q,      // Read strobe
  input wire logic        fr_wr_q,      // Write strobe
  input wire logic [7:0]  fr_wdata_q,   // Write data
  input wire logic [7:0]  acc_q,        // Accumulator
  input wire logic        flag_n_q,     // Negative
  input wire logic        flag_z_q,     // Zero
  input wire logic        lp_second_q   // Pointer word 2
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] rdy_q;

  // One stage past the core's release, so $past never sees reset values
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdy_q <= 3'h0;
    end else begin
      rdy_q <= {rdy_q[1:0], 1'b1};
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rdy_q[2]);

  // Words taken at the end of Q1
  wire take = phase_q == 4'h1 && instr_valid && !lp_second_q;
  wire lit  = take && instr_word[15:8] == 8'h09;
  wire oro  = take && instr_word[15:10] == 6'h04;
  wire rop  = oro || (take && instr_word[15:10] == 6'h14);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_phase_turn: assert property (phase_q == {$past(phase_q[2:0]), $past(phase_q[3])})
    else $error("phase did not rotate");
  chk_wr_q4: assert property (fr_wr_q |-> phase_q == 4'h8)
    else $error("write outside Q4");
  chk_rd_q2: assert property (fr_rd_q |-> phase_q == 4'h2)
    else $error("read outside Q2");
  chk_lit_acc: assert property (lit |=> ##3 acc_q == ($past(acc_q, 4) | $past(instr_word[7:0], 4)))
    else $error("literal OR result wrong");
  chk_lit_flags: assert property (lit |=> ##3 flag_n_q == acc_q[7] && flag_z_q == (acc_q == 8'h00))
    else $error("flags wrong after literal OR");
  chk_access_addr: assert property (rop && !instr_word[8] |=>
    fr_addr_q == {($past(instr_word[7]) ? 4'hf : 4'h0), $past(instr_word[7:0])})
    else $error("access bank address wrong");
  chk_bank_addr: assert property (rop && instr_word[8] |=>
    fr_addr_q == {$past(bank_sel), $past(instr_word[7:0])})
    else $error("banked address wrong");
  chk_dest_wr: assert property (rop |=> ##2 fr_wr_q == $past(instr_word[9], 3))
    else $error("write strobe disagrees with destination");
  chk_or_wdata: assert property (oro && instr_word[9] |=> ##2 fr_wdata_q == ($past(acc_q, 3) | $past(fr_rdata, 2)))
    else $error("register OR data wrong");
  chk_ptr_flags: assert property (lp_second_q |-> $stable({flag_n_q, flag_z_q, acc_q}))
    else $error("pointer load touched flags");

  // Main scenarios reached
  cov_lit: cover property (lit);
  cov_wr: cover property (fr_wr_q);
  cov_lp: cover property ($rose(lp_second_q));
endmodule // omlpe_core_sva

bind omlpe_core omlpe_core_sva u_sva (
  .clk         (clk),
  .nrst        (nrst),
  .instr_word  (instr_word),
  .instr_valid (instr_valid),
  .bank_sel    (bank_sel),
  .fr_rdata    (fr_rdata),
  .phase_q     (phase_q),
  .fr_addr_q   (fr_addr_q),
  .fr_rd_q     (fr_rd_q),
  .fr_wr_q     (fr_wr_q),
  .fr_wdata_q  (fr_wdata_q),
  .acc_q       (acc_q),
  .flag_n_q    (flag_n_q),
  .flag_z_q    (flag_z_q),
  .lp_second_q (lp_second_q)
);

// ===== omlpe_core_tb_top.sv
module omlpe_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic v; logic [15:0] w; logic [3:0] b; logic [9:0] e;} omlpe_row_t;
  logic clk = 1'b0;
  logic nrst, instr_valid, rd, wr, n, z, lp;
  logic [15:0] instr_word;
  logic [3:0] bank_sel, phase_q;
  logic [7:0] rdata, wdata, acc;
  logic [11:0] addr;
  logic [35:0] ptr;
  int err_count = 0;
  int n_tests = 0;
  // Expected {n, z, acc} chains from one row to the next
  omlpe_row_t rows [10] = '{'{1, 16'h099a, 4'h0, 10'h29a}, '{1, 16'h0935, 4'h0, 10'h2bf},
    '{1, 16'h5085, 4'ha, 10'h100}, '{1, 16'h1012, 4'ha, 10'h013}, '{1, 16'h1345, 4'h3, 10'h213},
    '{1, 16'h5345, 4'h3, 10'h213}, '{1, 16'h51ff, 4'hf, 10'h07f}, '{0, 16'h0980, 4'h0, 10'h07f},
    '{1, 16'hffff, 4'h0, 10'h07f}, '{1, 16'h5145, 4'h3, 10'h293}};

  omlpe_core #(.NUM_PTR(3)) uut (.clk(clk), .nrst(nrst), .instr_word(instr_word),
    .instr_valid(instr_valid), .bank_sel(bank_sel), .fr_rdata(rdata), .phase_q(phase_q),
    .fr_addr_q(addr), .fr_rd_q(rd), .fr_wr_q(wr), .fr_wdata_q(wdata), .acc_q(acc),
    .flag_n_q(n), .flag_z_q(z), .lp_second_q(lp), .ptr_q(ptr));
  omlpe_mem u_mem (.clk(clk), .fr_addr(addr), .fr_rd(rd), .fr_wr(wr), .fr_wdata(wdata),
    .fr_rdata(rdata));

  // Clock
  always #50 clk = ~clk;

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic summarize();
    if (err_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(string nm, logic [35:0] seen, logic [35:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Holds the request over the whole cycle; result is settled on return
  task automatic issue(logic v, logic [15:0] w, logic [3:0] b);
    int k;
    k = 0;
    while (phase_q !== 4'h1 && k < 8) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 8) begin
      err_count++;
      summarize();
    end
    instr_valid = v;
    instr_word = w;
    bank_sel = b;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // Sync release takes two edges, then one more to leave Q1
  task automatic do_reset();
    nrst = 1'b0;
    instr_valid = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    instr_word = 16'h0000;
    bank_sel = 4'h0;
    u_mem.m[12'h012] = 8'h13;
    u_mem.m[12'hf85] = 8'h00;
    u_mem.m[12'h345] = 8'h80;
    u_mem.m[12'hfff] = 8'h7f;
    u_mem.m[12'ha12] = 8'h55;
    u_mem.m[12'h085] = 8'h55;
    do_reset();
    check("reset", 36'({lp, n, z, acc}), 36'h0);
    foreach (rows[i]) begin
      issue(rows[i].v, rows[i].w, rows[i].b);
      check("nz_acc", 36'({n, z, acc}), 36'(rows[i].e));
    end
    check("mem345", 36'(u_mem.m[12'h345]), 36'h93);
    check("mem012", 36'(u_mem.m[12'h012]), 36'h13);
    issue(1'b1, 16'hee23, 4'h0);
    check("ptr_hi", ptr, 36'h300000000);
    check("lp_set", 36'({lp, n, z, acc}), 36'h693);
    issue(1'b1, 16'hf0ab, 4'h0);
    check("ptr_lo", ptr, 36'h3ab000000);
    check("lp_clr", 36'({lp, n, z, acc}), 36'h293);
    issue(1'b1, 16'hee35, 4'h0);
    issue(1'b1, 16'hf0cd, 4'h0);
    check("ptr_bad_idx", ptr, 36'h3ab000000);
    issue(1'b1, 16'hee14, 4'h0);
    issue(1'b1, 16'h09ff, 4'h0);
    check("ptr_no_w2", ptr, 36'h3ab400000);
    check("acc_no_w2", 36'({lp, n, z, acc}), 36'h293);
    @(posedge clk);
    #1;
    nrst = 1'b0;
    #1;
    check("mid_reset", 36'({phase_q, lp, n, z, acc}) | ptr, 36'h800);
    do_reset();
    issue(1'b1, 16'h0942, 4'h0);
    check("after_reset", 36'({n, z, acc}), 36'h042);
    summarize();
  end
endmodule // omlpe_core_tb_top

// ===== omlpe_dec_if.sv
interface omlpe_dec_if;
  logic [omlpe_pkg::WORD_W-1:0] word;
  logic                         second;
  logic                         valid;
  omlpe_pkg::omlpe_op_t         op;
  logic                         dest;
  logic                         abit;
  logic [omlpe_pkg::DATA_W-1:0] field;
  logic [omlpe_pkg::PIDX_W-1:0] pidx;
  logic [omlpe_pkg::KHI_W-1:0]  khi;

  modport dec  (input word, second, valid, output op, dest, abit, field, pidx, khi);
  modport core (output word, second, valid, input op, dest, abit, field, pidx, khi);
endinterface

// ===== omlpe_decode.sv
module omlpe_decode (
  omlpe_dec_if.dec d  // Word in, decoded fields out
);

  // ----------------------------------------------------------------
  // Opcode matches
  // ----------------------------------------------------------------
  wire m_or_lit = d.word[15:8] == omlpe_pkg::OPC_OR_LIT;   // RL1
  wire m_or_reg = d.word[15:10] == omlpe_pkg::OPC_OR_REG;  // RL4
  wire m_copy   = d.word[15:10] == omlpe_pkg::OPC_COPY_REG; // RL11
  wire m_ldp1   = d.word[15:6] == omlpe_pkg::OPC_LDPTR_1;  // RL10
  wire m_ldp2   = d.word[15:8] == omlpe_pkg::OPC_LDPTR_2;  // RL13

  // Second word of a pointer load is never decoded as a fresh opcode
  always_comb begin
    d.op = omlpe_pkg::OP_NONE;
    if (!d.valid) begin
      d.op = omlpe_pkg::OP_NONE;
    end else if (d.second) begin
      d.op = m_ldp2 ? omlpe_pkg::OP_LDP_LO : omlpe_pkg::OP_NONE; // RL13
    end else if (m_or_lit) begin
      d.op = omlpe_pkg::OP_OR_LIT;
    end else if (m_or_reg) begin
      d.op = omlpe_pkg::OP_OR_REG;
    end else if (m_copy) begin
      d.op = omlpe_pkg::OP_COPY;
    end else if (m_ldp1) begin
      d.op = omlpe_pkg::OP_LDP_HI;
    end
  end

  // Field extraction
  assign d.dest  = d.word[omlpe_pkg::DEST_BIT];  // RL6
  assign d.abit  = d.word[omlpe_pkg::ABIT_BIT];  // RL7
  assign d.field = d.word[omlpe_pkg::DATA_W-1:0]; // RL9
  assign d.pidx  = d.word[omlpe_pkg::PIDX_LSB +: omlpe_pkg::PIDX_W];
  assign d.khi   = d.word[omlpe_pkg::KHI_LSB +: omlpe_pkg::KHI_W];

endmodule // omlpe_decode

// ===== omlpe_mem.sv
module omlpe_mem (
  input  wire logic        clk,       // Clock
  input  wire logic [11:0] fr_addr,   // Address
  input  wire logic        fr_rd,     // Read strobe
  input  wire logic        fr_wr,     // Write strobe
  input  wire logic [7:0]  fr_wdata,  // Write data
  output logic      [7:0]  fr_rdata   // Read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] m [0:4095];  // All banks

  // Inverse when not read, so stale data never passes as valid
  assign fr_rdata = fr_rd ? m[fr_addr] : ~m[fr_addr];

  // Store on the strobe
  always @(posedge clk) begin
    if (fr_wr) begin
      m[fr_addr] <= fr_wdata;
    end
  end
endmodule // omlpe_mem

// ===== omlpe_pkg.sv
package omlpe_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 12;
  localparam int WORD_W  = 16;
  localparam int BANK_W  = 4;
  localparam int PTR_W   = 12;
  localparam int PIDX_W  = 2;

  // ----------------------------------------------------------------
  // Opcode fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_OR_LIT   = 8'h09; // Full upper byte
  localparam logic [5:0] OPC_OR_REG   = 6'h04; // 000100 da
  localparam logic [5:0] OPC_COPY_REG = 6'h14; // 010100 da
  localparam logic [9:0] OPC_LDPTR_1  = 10'h3b8; // 1110 1110 00, ptr index, k msb
  localparam logic [7:0] OPC_LDPTR_2  = 8'hf0;   // 1111 0000, k lsb
  localparam int DEST_BIT  = 9;
  localparam int ABIT_BIT  = 8;
  localparam int PIDX_LSB  = 4;
  localparam int KHI_LSB   = 0;
  localparam int KHI_W     = 4;

  // ----------------------------------------------------------------
  // Access bank map: low part at bank 0, high part at top bank
  // ----------------------------------------------------------------
  localparam logic [7:0]        ACCESS_SPLIT   = 8'h80;
  localparam logic [BANK_W-1:0] ACCESS_BANK_LO = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_BANK_HI = 4'hf;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [PTR_W-1:0]  PTR_RST = 12'h000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } omlpe_phase_t;

  typedef enum logic [2:0] {
    OP_NONE   = 3'h0,
    OP_OR_LIT = 3'h1,
    OP_OR_REG = 3'h2,
    OP_COPY   = 3'h3,
    OP_LDP_HI = 3'h4,
    OP_LDP_LO = 3'h5
  } omlpe_op_t;

endpackage
